// ---- src/dhc_defines.svh ----
`ifndef DHC_DEFINES_SVH
`define DHC_DEFINES_SVH

// clock period in picoseconds (125 MHz)
`define DHC_CLK_PERIOD_PS 8000
// revolution period in nanoseconds
`define DHC_REV_PERIOD_NS 16670000
// revolution period in clock cycles, rounded down; the period is scaled
// by ten and the clock by a hundredth so the product fits in 32 bits
`define DHC_REV_CYCLES \
    ((`DHC_REV_PERIOD_NS * 10) / (`DHC_CLK_PERIOD_PS / 100))
// width of the revolution mark pulse in nanoseconds
`define DHC_MARK_WIDTH_NS 1000
`define DHC_MARK_CYCLES \
    (((`DHC_MARK_WIDTH_NS * 1000) + `DHC_CLK_PERIOD_PS - 1) \
    / `DHC_CLK_PERIOD_PS)
// settle time after the last step, nanoseconds
`define DHC_SETTLE_NS 2000
`define DHC_SETTLE_CYCLES \
    (((`DHC_SETTLE_NS * 1000) + `DHC_CLK_PERIOD_PS - 1) \
    / `DHC_CLK_PERIOD_PS)
// highest head number and chip enable split
`define DHC_MAX_HEAD 4'h6
`define DHC_LOW_GROUP_LAST 4'h3
// outermost cylinder
`define DHC_OUTER_CYL 11'h000
`define DHC_CYL_W 11

`endif

// ---- src/dhc_drive_head_control.sv ----
`timescale 1ns/1ps
`include "dhc_defines.svh"
// Functional notes
// [R1] direction high at step means outward, low means inward
// [R2] control lines act only while unit select is low
// [R3] head number is binary active low; all inactive selects head 0
// [R4] one active-low revolution mark per 16.67 ms revolution
// [R5] two binary head bits shared by both preamp ICs
// [R6] two active-low chip enables, at most one asserted
// [R7] each step pulse moves heads exactly one track; a step against either end stop leaves the cylinder unchanged but still restarts the settle timer
// [R8] first enable for heads 0 to 3, second for heads 4 to 6
// [R9] outer cylinder flag low while at cylinder 0; reset sets it high until the first clock after reset
// [R10] settle done low once heads settled on final track

module dhc_drive_head_control
    import dhc_pkg::*;
#(
    parameter int REV_CYCLES = `DHC_REV_CYCLES, // cycles per revolution
    parameter int CYL_COUNT = 1024 // number of cylinders
) (
    input wire logic clock, // 125 MHz clock
    input wire logic resetn, // async reset, active low
    input wire logic unit_select_n, // drive select, active low
    input wire logic step_n, // step pulse, active low
    input wire logic direction_n, // low = inward
    input wire logic head_number_bit0_n, // head number bit 0, active low
    input wire logic head_number_bit1_n, // head number bit 1, active low
    input wire logic head_number_bit2_n, // head number bit 2, active low
    input wire logic head_number_bit3_n, // head number bit 3, active low
    output logic preamp_head_bit_a, // head bit within ic
    output logic preamp_head_bit_b, // head bit within ic
    output logic preamp_enable_low_heads_n, // ic enable heads 0-3
    output logic preamp_enable_high_heads_n, // ic enable heads 4-6
    output logic revolution_mark_n, // index pulse, active low
    output logic outer_cylinder_flag_n, // track zero, active low
    output logic settle_done_n, // seek complete, active low
    output logic [`DHC_CYL_W-1:0] cylinder // current cylinder
);

    localparam int SETTLE_CYCLES = `DHC_SETTLE_CYCLES;
    localparam int MARK_CYCLES = `DHC_MARK_CYCLES;
    localparam logic [`DHC_CYL_W-1:0] LAST_CYL =
        `DHC_CYL_W'(CYL_COUNT - 1);

    ////////////////////////////////////////////////////////////////////////
    // shared arithmetic

    // true once a counter has reached the last value of its span; both
    // the settle timer and the revolution counter end this way
    function automatic logic reachedLast(
        input logic [31:0] count,
        input int span
    );
        return count >= 32'(span - 1);
    endfunction

    // one track toward the centre or toward the rim; a step against
    // either end stop is swallowed, since the actuator has nowhere to go
    function automatic logic [`DHC_CYL_W-1:0] stepTarget(
        input logic [`DHC_CYL_W-1:0] from,
        input logic outward,
        input logic [`DHC_CYL_W-1:0] lastCyl
    );
        logic [`DHC_CYL_W-1:0] target;
        target = from;
        if (outward) begin
            if (from != `DHC_OUTER_CYL) begin
                target = from - 1'b1;
            end
        end else if (from != lastCyl) begin
            target = from + 1'b1;
        end
        return target;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // head selection

    logic [3:0] headNumber;
    logic [3:0] heldHead;
    logic [3:0] next_heldHead;
    dhc_preamp_t decoded;

    // inverting active-low lines makes all-inactive read as head 0
    assign headNumber = {~head_number_bit3_n, ~head_number_bit2_n,
                         ~head_number_bit1_n, ~head_number_bit0_n}; // [R3]

    // a deselected drive keeps its last head
    always_comb begin
        next_heldHead = heldHead;
        if (!unit_select_n) begin
            next_heldHead = headNumber; // [R2]
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            heldHead <= 4'h0;
        end else begin
            heldHead <= next_heldHead;
        end
    end

    dhc_head_decode headDecode (
        .headNumber(next_heldHead),
        .preamp(decoded)
    );

    // outputs registered so the preamp lines never glitch
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            preamp_head_bit_a <= 1'b0;
            preamp_head_bit_b <= 1'b0;
            preamp_enable_low_heads_n <= 1'b0;
            preamp_enable_high_heads_n <= 1'b1;
        end else begin
            preamp_head_bit_a <= decoded.headBitA; // [R5]
            preamp_head_bit_b <= decoded.headBitB; // [R5]
            preamp_enable_low_heads_n <= decoded.enableLow_n; // [R6]
            preamp_enable_high_heads_n <= decoded.enableHigh_n; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step handling and cylinder position

    logic stepPrev;
    logic stepEdge;
    dhc_seek_t seekState;
    dhc_seek_t next_seekState;
    logic [`DHC_CYL_W-1:0] next_cylinder;
    logic [31:0] settleCount;
    logic [31:0] next_settleCount;
    logic next_settleDone_n;
    logic next_outerFlag_n;

    // falling edge of step counted only while selected
    assign stepEdge = stepPrev && !step_n && !unit_select_n; // [R2] [R7]

    // move one track per step, clamped at both ends; restart settle timer
    always_comb begin
        next_cylinder = cylinder;
        next_seekState = seekState;
        next_settleCount = settleCount;
        next_settleDone_n = settle_done_n;
        if (stepEdge) begin
            // direction is taken at the step edge, not when settled
            next_cylinder =
                stepTarget(cylinder, direction_n, LAST_CYL); // [R1] [R7]
            next_seekState = DHC_SETTLE;
            next_settleCount = 32'h0;
            next_settleDone_n = 1'b1; // [R10]
        end else begin
            unique case (seekState)
                DHC_IDLE: begin
                    next_settleDone_n = 1'b0;
                end
                DHC_SETTLE: begin
                    // waits for settle time after the last step
                    if (reachedLast(settleCount, SETTLE_CYCLES)) begin
                        next_seekState = DHC_IDLE;
                        next_settleDone_n = 1'b0; // [R10]
                    end else begin
                        next_settleCount = settleCount + 32'h1;
                    end
                end
                default: begin
                    next_seekState = DHC_IDLE;
                end
            endcase
        end
        // flag follows the new position so both change on one edge
        next_outerFlag_n = (next_cylinder != `DHC_OUTER_CYL); // [R9]
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stepPrev <= 1'b1;
            seekState <= DHC_IDLE;
            cylinder <= `DHC_OUTER_CYL;
            settleCount <= 32'h0;
            settle_done_n <= 1'b1;
            outer_cylinder_flag_n <= 1'b1;
        end else begin
            stepPrev <= step_n;
            seekState <= next_seekState;
            cylinder <= next_cylinder;
            settleCount <= next_settleCount;
            settle_done_n <= next_settleDone_n;
            outer_cylinder_flag_n <= next_outerFlag_n; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // revolution mark generator

    logic [31:0] revCount;
    logic [31:0] next_revCount;
    logic next_mark_n;

    // free-running count; mark low for the first cycles of each turn
    always_comb begin
        if (reachedLast(revCount, REV_CYCLES)) begin
            next_revCount = 32'h0;
        end else begin
            next_revCount = revCount + 32'h1;
        end
        next_mark_n = !(next_revCount < 32'(MARK_CYCLES)); // [R4]
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // start on the last count so the first mark is full width
            revCount <= 32'(REV_CYCLES - 1);
            revolution_mark_n <= 1'b1;
        end else begin
            revCount <= next_revCount;
            revolution_mark_n <= next_mark_n; // [R4]
        end
    end

endmodule

// ---- src/dhc_head_decode.sv ----
`timescale 1ns/1ps
`include "dhc_defines.svh"

module dhc_head_decode
    import dhc_pkg::*;
(
    input wire logic [3:0] headNumber, // binary head number, active high
    output dhc_preamp_t preamp // decoded preamp controls
);

    // split head number into ic enable and head within ic
    always_comb begin
        preamp.headBitA = headNumber[0]; // [R5]
        preamp.headBitB = headNumber[1]; // [R5]
        preamp.enableLow_n = 1'b1;
        preamp.enableHigh_n = 1'b1;
        // invalid heads enable neither ic
        if (headNumber <= `DHC_LOW_GROUP_LAST) begin
            preamp.enableLow_n = 1'b0; // [R8]
        end else if (headNumber <= `DHC_MAX_HEAD) begin
            preamp.enableHigh_n = 1'b0; // [R8] [R6]
        end
    end

endmodule

// ---- src/dhc_pkg.sv ----
package dhc_pkg;

    // seek engine states
    typedef enum logic [1:0] {
        DHC_IDLE = 2'b00,
        DHC_SETTLE = 2'b01
    } dhc_seek_t;

    // signals toward the preamplifier ICs
    typedef struct packed {
        logic enableLow_n;
        logic enableHigh_n;
        logic headBitA;
        logic headBitB;
    } dhc_preamp_t;

endpackage

// ---- testbench/dhc_ctrl_model.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// controller side: drive select, step, direction and head lines
module dhc_ctrl_model (
    input wire logic clock, // bench clock
    output logic unitSel_n, // drive select
    output logic step_n, // step strobe
    output logic dir_n, // direction
    output logic [3:0] head_n // head number, active low
);
    // idle: deselected, no step, outward, head 0
    initial begin
        unitSel_n = 1'b1;
        step_n = 1'b1;
        dir_n = 1'b1;
        head_n = 4'hf;
    end
    // step low one cycle, high two, so each pulse is seen once
    task automatic step(input bit inward);
        @(posedge clock);
        dir_n <= ~inward;
        step_n <= 1'b0;
        @(posedge clock);
        step_n <= 1'b1;
        @(posedge clock);
    endtask
    // binary head number on active-low lines
    task automatic pick(input logic [3:0] h, input logic sel_n);
        @(posedge clock);
        unitSel_n <= sel_n;
        head_n <= ~h;
    endtask
endmodule

// ---- testbench/dhc_drive_head_control_asserts.sv ----
`timescale 1ns/1ps
`include "dhc_defines.svh"
module dhc_drive_head_control_asserts
    import dhc_pkg::*;
#(
    parameter int REV_CYCLES = `DHC_REV_CYCLES, // cycles per revolution
    parameter int CYL_COUNT = 1024 // cylinders
) (
    input wire logic clock, // clock
    input wire logic resetn, // reset
    input wire logic unit_select_n, // select
    input wire logic step_n, // step
    input wire logic direction_n, // direction
    input wire logic head_number_bit0_n, // head
    input wire logic head_number_bit1_n, // head
    input wire logic head_number_bit2_n, // head
    input wire logic head_number_bit3_n, // head
    input wire logic preamp_head_bit_a, // bit a
    input wire logic preamp_head_bit_b, // bit b
    input wire logic preamp_enable_low_heads_n, // ic 0
    input wire logic preamp_enable_high_heads_n, // ic 1
    input wire logic revolution_mark_n, // index
    input wire logic outer_cylinder_flag_n, // track zero
    input wire logic settle_done_n, // settled
    input wire logic [`DHC_CYL_W-1:0] cylinder // position
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [3:0] hn;
    logic sel;
    logic lo_n;
    logic hi_n;
    // decoded head number; the head bits are checked for heads 0 to 6 only
    assign hn = ~{head_number_bit3_n, head_number_bit2_n,
        head_number_bit1_n, head_number_bit0_n};
    assign sel = !unit_select_n;
    assign lo_n = preamp_enable_low_heads_n;
    assign hi_n = preamp_enable_high_heads_n;
    //////////////////////////////////////////////////////////////////////////
    head_bits_a: assert property (
        sel && hn < 7 |=> preamp_head_bit_a == $past(hn[0])
        && preamp_head_bit_b == $past(hn[1])) else $error("head bits");
    low_group_a: assert property (
        sel && hn < 4 |=> !lo_n && hi_n) else $error("low enable");
    high_group_a: assert property (
        sel && hn inside {[4:6]} |=> lo_n && !hi_n) else $error("hi enable");
    one_enable_a: assert property (lo_n || hi_n)
        else $error("two enables");
    held_head_a: assert property (
        !sel |=> $stable({preamp_head_bit_a, preamp_head_bit_b, lo_n, hi_n}))
        else $error("head moved");
    step_in_a: assert property (
        $fell(step_n) && sel && !direction_n && cylinder < CYL_COUNT - 1
        |=> cylinder == $past(cylinder) + 1) else $error("step in");
    step_out_a: assert property (
        $fell(step_n) && sel && direction_n && cylinder > 0
        |=> cylinder == $past(cylinder) - 1) else $error("step out");
    outer_flag_a: assert property (
        $past(resetn) |-> outer_cylinder_flag_n == (cylinder != 0))
        else $error("track zero");
    settle_busy_a: assert property (
        $fell(step_n) && sel |=> settle_done_n [*8]) else $error("settle");
    mark_width_a: assert property (
        $fell(revolution_mark_n) |-> !revolution_mark_n [*8])
        else $error("mark width");
    cover property ($fell(revolution_mark_n));
    cover property ($fell(settle_done_n));
    cover property (sel && hn == 6);
endmodule
bind dhc_drive_head_control dhc_drive_head_control_asserts #(
    .REV_CYCLES(REV_CYCLES), .CYL_COUNT(CYL_COUNT)) u_chk (
    .clock(clock), .resetn(resetn), .unit_select_n(unit_select_n),
    .step_n(step_n), .direction_n(direction_n),
    .head_number_bit0_n(head_number_bit0_n),
    .head_number_bit1_n(head_number_bit1_n),
    .head_number_bit2_n(head_number_bit2_n),
    .head_number_bit3_n(head_number_bit3_n),
    .preamp_head_bit_a(preamp_head_bit_a),
    .preamp_head_bit_b(preamp_head_bit_b),
    .preamp_enable_low_heads_n(preamp_enable_low_heads_n),
    .preamp_enable_high_heads_n(preamp_enable_high_heads_n),
    .revolution_mark_n(revolution_mark_n),
    .outer_cylinder_flag_n(outer_cylinder_flag_n),
    .settle_done_n(settle_done_n), .cylinder(cylinder));

// ---- testbench/drive_head_control_port_tb.sv ----
`timescale 1ns/1ps
`include "dhc_defines.svh"
module drive_head_control_port_tb;
    localparam int REV = 1000;
    localparam int NCYL = 8;
    logic clock, resetn, unitSel_n, step_n, dir_n, bitA, bitB;
    logic enLow_n, enHigh_n, mark_n, outer_n, done_n;
    logic [3:0] head_n;
    logic [10:0] cylinder;
    int mismatches, n_tests, cyl, t0;
    int expQ[$];
    bit inward;
    // free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    dhc_ctrl_model u_ctl (.clock(clock), .unitSel_n(unitSel_n),
        .step_n(step_n), .dir_n(dir_n), .head_n(head_n));
    dhc_drive_head_control #(.REV_CYCLES(REV), .CYL_COUNT(NCYL)) u_dut (
        .clock(clock), .resetn(resetn), .unit_select_n(unitSel_n),
        .step_n(step_n), .direction_n(dir_n),
        .head_number_bit0_n(head_n[0]), .head_number_bit1_n(head_n[1]),
        .head_number_bit2_n(head_n[2]), .head_number_bit3_n(head_n[3]),
        .preamp_head_bit_a(bitA), .preamp_head_bit_b(bitB),
        .preamp_enable_low_heads_n(enLow_n),
        .preamp_enable_high_heads_n(enHigh_n),
        .revolution_mark_n(mark_n), .outer_cylinder_flag_n(outer_n),
        .settle_done_n(done_n), .cylinder(cylinder));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // expected enables and bits worked out from the head number
    task automatic head_case(input int h);
        expQ.push_back({h > 3, h < 4 || h > 6});
        if (h < 7) expQ.push_back({h[0], h[1]});
        u_ctl.pick(h[3:0], 1'b0);
        repeat (2) @(negedge clock);
        chk({enLow_n, enHigh_n}, 16'(expQ.pop_front()));
        if (h < 7) chk({bitA, bitB}, 16'(expQ.pop_front()));
    endtask
    // bounded wait on the index line, counting cycles in t0
    task automatic until_mark(input logic lv);
        while (mark_n !== lv && t0 < 3 * REV) begin
            @(negedge clock);
            t0++;
        end
    endtask
    // hang guard, well beyond the expected run
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        complete_run();
    end
    initial begin
        resetn = 1'b0;
        mismatches = 0;
        n_tests = 0;
        void'($urandom(32'hf0bf));
        repeat (16) @(posedge clock);
        chk({outer_n, done_n}, 16'h3);
        chk({mark_n, enLow_n, enHigh_n}, 16'h5);
        resetn <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            head_case(i < 16 ? i : int'($urandom() % 16));
        end
        // head lines change while deselected: head 5 must stay
        head_case(5);
        u_ctl.pick(4'h1, 1'b1);
        repeat (3) @(negedge clock);
        chk({enLow_n, enHigh_n, bitA, bitB}, 16'ha);
        $display("head test done");
        u_ctl.pick(4'h0, 1'b0);
        cyl = 0;
        // run into both end stops, then wander at random
        for (int i = 0; i < 30; i++) begin
            inward = i < 10 ? 1'b1 : (i < 20 ? 1'b0 : 1'($urandom()));
            u_ctl.step(inward);
            if (inward && cyl < NCYL - 1) cyl++;
            else if (!inward && cyl > 0) cyl--;
            @(negedge clock);
            chk(cylinder, cyl);
            chk({outer_n, done_n}, {cyl != 0, 1'b1});
        end
        t0 = 0;
        while (done_n !== 1'b0 && t0 < 300) begin
            @(negedge clock);
            t0++;
        end
        // the step edge came one cycle before the step task returned
        chk(t0, `DHC_SETTLE_CYCLES - 1);
        u_ctl.pick(4'h0, 1'b1);
        u_ctl.step(cyl == 0);
        @(negedge clock);
        chk(cylinder, cyl);
        chk(done_n, 1'b0);
        $display("step test done");
        // leave any mark in progress first, so a whole one is measured
        t0 = 0;
        until_mark(1'b1);
        until_mark(1'b0);
        t0 = 0;
        until_mark(1'b1);
        chk(t0, `DHC_MARK_CYCLES);
        until_mark(1'b0);
        chk(t0, REV);
        $display("index test done");
        complete_run();
    end
endmodule
